// *** verilog/pll_synth_pkg.sv ***
// constants shared by the synthesizer divider control block
// assumes one 100 MHz system clock and a 7.2 MHz crystal enable pulse
// Overview of operation
// [R1] crystal reference divider, 13 codes, stop, reserved
// [R2] two-bit path selector picks pin and mode
// [R3] unselected vco pins are pulled down
// [R4] direct mode uses programmable counter only
// [R5] swallow modes use 16/17 prescaler chain
// [R6] 4-bit swallow and 12-bit main down counters
// [R7] direct mode loads upper 12 data bits
// [R8] swallow modes load 12 main, 4 swallow
// [R9] counters reload through intermediate data buffer
// [R10] division data register is readable and writable
// [R11] software keeps division value within legal range
// [R12] comparator makes up/down requests from phases
// [R13] error pin drives high, low or floats
// [R14] two unlock flags, cleared on read
// [R15] software never writes reserved bits or codes
// [R16] up active low, down active high
// [R17] software polls flags slower than reference
// [R18] prescale 17 until swallow empty, then 16
// [R19] mode register reads zero after reset
package pll_synth_pkg;
	localparam logic [7:0] MODE_ADDR = 8'hf1;
	localparam logic [7:0] DATA_HI_ADDR = 8'hf2;
	localparam logic [7:0] DATA_LO_ADDR = 8'hf3;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	// mode register field positions
	localparam int REF_SEL_LSB = 4;
	localparam int UNLOCK_HI_BIT = 3;
	localparam int UNLOCK_LO_BIT = 2;
	localparam int PATH_SEL_LSB = 0;
	// divider path codes
	localparam logic [1:0] PATH_OFF = 2'h0;
	localparam logic [1:0] PATH_VHF = 2'h1;
	localparam logic [1:0] PATH_HF = 2'h2;
	localparam logic [1:0] PATH_MF = 2'h3;
	// prescaler moduli, counted from zero
	localparam logic [4:0] PRESCALE_16_LAST = 5'h0f;
	localparam logic [4:0] PRESCALE_17_LAST = 5'h10;
	// reference divide ratios from 7.2 MHz crystal
	localparam logic [12:0] REF_DIV_1K = 13'd7200;
	localparam logic [12:0] REF_DIV_1K25 = 13'd5760;
	localparam logic [12:0] REF_DIV_2K5 = 13'd2880;
	localparam logic [12:0] REF_DIV_3K = 13'd2400;
	localparam logic [12:0] REF_DIV_5K = 13'd1440;
	localparam logic [12:0] REF_DIV_6K25 = 13'd1152;
	localparam logic [12:0] REF_DIV_9K = 13'd800;
	localparam logic [12:0] REF_DIV_10K = 13'd720;
	localparam logic [12:0] REF_DIV_12K5 = 13'd576;
	localparam logic [12:0] REF_DIV_18K = 13'd400;
	localparam logic [12:0] REF_DIV_20K = 13'd360;
	localparam logic [12:0] REF_DIV_25K = 13'd288;
	localparam logic [12:0] REF_DIV_50K = 13'd144;
	localparam logic [12:0] REF_DIV_NONE = 13'd0;
	localparam logic [3:0] REF_CODE_LAST = 4'hd;
	// default unlock detector error widths, system clocks per period
	localparam int UNLOCK_WIDTH_HI = 111;
	localparam int UNLOCK_WIDTH_LO = 222;
	typedef enum logic [1:0] {pfd_idle, pfd_up, pfd_down} pfd_state_t;
endpackage

// *** verilog/pll_synth_divider_control.sv ***
// digital part of the frequency synthesizer: selector, divider, reference,
// phase comparator, error pin and unlock flags behind three sfr registers
// assumes vco inputs already squared and synchronous to sys_clk
module pll_synth_divider_control #(
	parameter int UNLOCK_HI_CYCLES = pll_synth_pkg::UNLOCK_WIDTH_HI,
	parameter int UNLOCK_LO_CYCLES = pll_synth_pkg::UNLOCK_WIDTH_LO
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// crystal rate enable, one pulse per 7.2 MHz period
	input wire logic xtal_en,
	// special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	// vco inputs and their pull-downs
	input wire logic vco_high_band_in,
	input wire logic vco_low_band_in,
	output logic vco_high_pulldown,
	output logic vco_low_pulldown,
	// charge pump error pin, enable low while driven
	output logic phase_error_out,
	output logic phase_error_oe_n,
	// comparator requests
	output logic upper_request_n,
	output logic lower_request
);
	import pll_synth_pkg::*;

	// elaboration check: the error width counter is only 16 bits wide
	if (UNLOCK_HI_CYCLES < 1 || UNLOCK_LO_CYCLES < 1 || UNLOCK_HI_CYCLES > 65535 ||
		UNLOCK_LO_CYCLES > 65535) begin : bad_unlock_widths
		$error("unlock widths must lie in 1..65535");
	end

	// reference ratio per code, zero means stopped or reserved
	function automatic logic [12:0] ref_ratio(input logic [3:0] code);
		case (code)
			4'h1: ref_ratio = REF_DIV_1K;
			4'h2: ref_ratio = REF_DIV_1K25;
			4'h3: ref_ratio = REF_DIV_2K5;
			4'h4: ref_ratio = REF_DIV_3K;
			4'h5: ref_ratio = REF_DIV_5K;
			4'h6: ref_ratio = REF_DIV_6K25;
			4'h7: ref_ratio = REF_DIV_9K;
			4'h8: ref_ratio = REF_DIV_10K;
			4'h9: ref_ratio = REF_DIV_12K5;
			4'ha: ref_ratio = REF_DIV_18K;
			4'hb: ref_ratio = REF_DIV_20K;
			4'hc: ref_ratio = REF_DIV_25K;
			4'hd: ref_ratio = REF_DIV_50K;
			default: ref_ratio = REF_DIV_NONE;
		endcase
	endfunction

	logic [3:0] ref_sel;
	logic [1:0] path_sel;
	logic unlock_flag_hi;
	logic unlock_flag_lo;
	logic [15:0] division_data;
	logic [15:0] data_buffer;
	logic [12:0] ref_count;
	logic [4:0] prescale_count;
	logic [3:0] swallow_down_counter;
	logic [11:0] main_down_counter;
	logic vco_prev;
	pfd_state_t pfd_state;
	logic [15:0] error_count;

	// register decode
	wire sel_mode = (sfr_addr == MODE_ADDR);
	wire sel_hi = (sfr_addr == DATA_HI_ADDR);
	wire sel_lo = (sfr_addr == DATA_LO_ADDR);
	wire wr_mode = sfr_wr && sel_mode;
	wire mode_read = sfr_rd && sel_mode;
	wire [7:0] mode_value = {ref_sel, unlock_flag_hi, unlock_flag_lo, path_sel};
	wire [7:0] read_value = sel_mode ? mode_value :
		sel_hi ? division_data[15:8] :
		sel_lo ? division_data[7:0] : 8'h00;

	// stopped when the reference code is zero or reserved
	wire [12:0] ref_div = ref_ratio(ref_sel); // [R1]
	wire running = (ref_div != REF_DIV_NONE) && (path_sel != PATH_OFF);
	wire direct_mode = (path_sel == PATH_MF); // [R2]

	// pin selection and pull-downs
	wire use_high = (path_sel == PATH_VHF); // [R2]
	wire use_low = (path_sel == PATH_HF) || (path_sel == PATH_MF); // [R2]
	assign vco_high_pulldown = !use_high; // [R3]
	assign vco_low_pulldown = !use_low; // [R3]
	wire vco_sel = use_high ? vco_high_band_in : (use_low && vco_low_band_in);
	wire vco_edge = running && vco_sel && !vco_prev;

	// reference tick at the end of each reference period
	wire ref_tick = running && xtal_en && (ref_count == 13'd0); // [R1]

	// prescaler: 17 while swallow count remains, 16 afterwards
	wire [4:0] prescale_last = (swallow_down_counter != 4'h0) ? PRESCALE_17_LAST :
		PRESCALE_16_LAST; // [R18]
	wire prescale_out = vco_edge && (prescale_count == prescale_last); // [R5]
	wire main_step = direct_mode ? vco_edge : prescale_out; // [R4]
	wire div_tick = main_step && (main_down_counter <= 12'h001);
	// upper 12 bits go to the main counter, lower 4 only when swallowing
	wire [11:0] main_load = data_buffer[15:4]; // [R7] [R8]
	wire [3:0] swallow_load = direct_mode ? 4'h0 : data_buffer[3:0]; // [R8]

	// error width thresholds
	wire [15:0] hi_limit = 16'(UNLOCK_HI_CYCLES);
	wire [15:0] lo_limit = 16'(UNLOCK_LO_CYCLES);
	wire err_active = (pfd_state != pfd_idle);
	wire set_hi = ref_tick && (error_count >= hi_limit);
	wire set_lo = ref_tick && (error_count >= lo_limit);

	// mode register, flags set win over the read clear
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ref_sel <= MODE_RESET[7:4]; // [R19]
			path_sel <= MODE_RESET[1:0]; // [R19]
			unlock_flag_hi <= 1'b0; // [R19]
			unlock_flag_lo <= 1'b0; // [R19]
		end else begin
			if (wr_mode) begin
				ref_sel <= sfr_wdata[REF_SEL_LSB +: 4];
				path_sel <= sfr_wdata[PATH_SEL_LSB +: 2];
			end
			unlock_flag_hi <= set_hi || (unlock_flag_hi && !mode_read); // [R14]
			unlock_flag_lo <= set_lo || (unlock_flag_lo && !mode_read); // [R14]
		end
	end

	// division data register and read port
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			division_data <= DATA_RESET;
			sfr_rdata <= 8'h00;
		end else begin
			if (sfr_wr && sel_hi) begin
				division_data[15:8] <= sfr_wdata; // [R10]
			end
			if (sfr_wr && sel_lo) begin
				division_data[7:0] <= sfr_wdata; // [R10]
			end
			if (sfr_rd) begin
				sfr_rdata <= read_value; // [R10]
			end
		end
	end

	// reference divider on crystal enable
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ref_count <= 13'd0;
		end else if (!running || wr_mode) begin
			ref_count <= 13'd0;
		end else if (xtal_en) begin
			ref_count <= (ref_count == 13'd0) ? ref_div - 13'd1 : ref_count - 13'd1; // [R1]
		end
	end

	// data buffer: takes the register at each division end and while stopped, so
	// counters never change their reload value in mid-division
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			data_buffer <= DATA_RESET;
		end else if (!running || div_tick) begin
			data_buffer <= division_data; // [R9]
		end
	end

	// division chain
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			vco_prev <= 1'b0;
			prescale_count <= 5'h00;
			swallow_down_counter <= 4'h0;
			main_down_counter <= 12'h000;
		end else begin
			vco_prev <= vco_sel;
			if (!running || div_tick) begin
				prescale_count <= 5'h00;
				swallow_down_counter <= swallow_load; // [R6] [R9]
				main_down_counter <= main_load; // [R6] [R9]
			end else begin
				if (vco_edge && !direct_mode) begin
					prescale_count <= prescale_out ? 5'h00 : prescale_count + 5'h01; // [R5]
				end
				if (prescale_out && !direct_mode && swallow_down_counter != 4'h0) begin
					swallow_down_counter <= swallow_down_counter - 4'h1; // [R6] [R18]
				end
				if (main_step) begin
					main_down_counter <= main_down_counter - 12'h001; // [R6]
				end
			end
		end
	end

	// phase comparator: the earlier edge opens a request, the later closes it
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pfd_state <= pfd_idle;
		end else if (!running) begin
			pfd_state <= pfd_idle;
		end else begin
			case (pfd_state)
				pfd_idle: begin
					if (div_tick && !ref_tick) begin
						pfd_state <= pfd_up; // [R12]
					end else if (ref_tick && !div_tick) begin
						pfd_state <= pfd_down; // [R12]
					end
				end
				pfd_up: begin
					if (ref_tick) begin
						pfd_state <= pfd_idle; // [R12]
					end
				end
				pfd_down: begin
					if (div_tick) begin
						pfd_state <= pfd_idle; // [R12]
					end
				end
				default: pfd_state <= pfd_idle;
			endcase
		end
	end

	// request outputs and error pin, floating when in phase
	assign upper_request_n = (pfd_state != pfd_up); // [R16]
	assign lower_request = (pfd_state == pfd_down); // [R16]
	assign phase_error_out = !upper_request_n; // [R13]
	assign phase_error_oe_n = upper_request_n && !lower_request; // [R13]

	// error width per reference period feeds the unlock flags;
	// software must poll slower than one period or it sees zeros
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			error_count <= 16'h0000;
		end else if (!running || ref_tick) begin
			error_count <= 16'h0000; // [R17]
		end else if (err_active && error_count != 16'hffff) begin
			error_count <= error_count + 16'h0001;
		end
	end
endmodule

// *** bench/vco_model.sv ***
// external vco model feeding the band pins of the block
// assumes the bench sets the period in sys_clk cycles, 2 or more
module vco_model (
	// clock and period
	input wire logic sys_clk,
	input wire logic [15:0] period,
	// pull-downs from the block, pins to it
	input wire logic vco_high_pulldown,
	input wire logic vco_low_pulldown,
	output logic vco_high_band_in,
	output logic vco_low_band_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] phase = 16'h0000;
	logic wave = 1'b0;
	// square wave; a new period takes effect within one old period
	always @(posedge sys_clk) begin
		phase <= (phase + 16'h0001 >= period) ? 16'h0000 : phase + 16'h0001;
		wave <= (phase < period / 2);
	end
	// a pulled-down pin reads low whatever the oscillator does
	assign vco_high_band_in = wave & ~vco_high_pulldown;
	assign vco_low_band_in = wave & ~vco_low_pulldown;
endmodule

// *** bench/pll_synth_checker.sv ***
// port checker for the synthesizer divider control block
// assumes one clock domain, bound into the divider control block below
module pll_synth_checker
	import pll_synth_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// register port
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	// pins and requests
	input wire logic vco_high_pulldown,
	input wire logic vco_low_pulldown,
	input wire logic phase_error_out,
	input wire logic phase_error_oe_n,
	input wire logic upper_request_n,
	input wire logic lower_request
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// decoded write and read facts, kept as wires so $past sees plain signals
	wire logic mode_wr = sfr_wr && sfr_addr == MODE_ADDR;
	wire logic sel_high = sfr_wdata[1:0] == PATH_VHF;
	wire logic sel_low = sfr_wdata[1];
	wire logic [5:0] wfields = {sfr_wdata[7:4], sfr_wdata[1:0]};
	wire logic hi_rd = sfr_rd && !sfr_wr && sfr_addr == DATA_HI_ADDR;
	wire logic odd_rd = sfr_rd && sfr_addr != MODE_ADDR && sfr_addr != DATA_HI_ADDR
		&& sfr_addr != DATA_LO_ADDR;
	req_exclusive_a: assert property (!(!upper_request_n && lower_request))
		else $error("up and down requests together");
	pin_float_a: assert property (phase_error_oe_n == (upper_request_n && !lower_request))
		else $error("error pin enable wrong");
	pin_level_a: assert property (!phase_error_oe_n |-> phase_error_out == !upper_request_n)
		else $error("error pin level wrong");
	high_pulldown_a: assert property (mode_wr |=> vco_high_pulldown != $past(sel_high))
		else $error("high pin pull-down wrong");
	low_pulldown_a: assert property (mode_wr |=> vco_low_pulldown != $past(sel_low))
		else $error("low pin pull-down wrong");
	// the bench leaves one idle cycle after every write strobe
	mode_readback_a: assert property (mode_wr ##2 (sfr_rd && !sfr_wr && sfr_addr == MODE_ADDR)
		|=> {sfr_rdata[7:4], sfr_rdata[1:0]} == $past(wfields, 3)) else $error("mode readback");
	data_readback_a: assert property (sfr_wr && sfr_addr == DATA_HI_ADDR ##2 hi_rd
		|=> sfr_rdata == $past(sfr_wdata, 3)) else $error("data readback");
	unmapped_read_a: assert property (odd_rd |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	reset_state_a: assert property ($rose(resetn) |-> sfr_rdata == 8'h00
		&& vco_high_pulldown && vco_low_pulldown) else $error("reset state wrong");
endmodule
bind pll_synth_divider_control pll_synth_checker chk (.sys_clk, .resetn, .sfr_addr, .sfr_wdata,
	.sfr_wr, .sfr_rd, .sfr_rdata, .vco_high_pulldown, .vco_low_pulldown, .phase_error_out,
	.phase_error_oe_n, .upper_request_n, .lower_request);

// *** bench/tb_top.sv ***
// self-checking bench for the synthesizer divider control block
// assumes the checker binds itself; crystal enable held high, ref = ratio cycles
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pll_synth_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic xtal_en = 1'b1;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [15:0] vco_per = 16'h000c;
	logic [7:0] sfr_rdata;
	logic vco_high_band_in, vco_low_band_in, vco_high_pulldown, vco_low_pulldown;
	logic phase_error_out, phase_error_oe_n, upper_request_n, lower_request;
	int error_cnt = 0;
	int comparisons = 0;
	always #5 sys_clk = ~sys_clk;
	// small unlock thresholds so one reference period sets both flags
	pll_synth_divider_control #(.UNLOCK_HI_CYCLES(2), .UNLOCK_LO_CYCLES(4)) dut (.sys_clk,
		.resetn, .xtal_en, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
		.vco_high_band_in, .vco_low_band_in, .vco_high_pulldown, .vco_low_pulldown,
		.phase_error_out, .phase_error_oe_n, .upper_request_n, .lower_request);
	vco_model vco (.sys_clk, .period(vco_per), .vco_high_pulldown, .vco_low_pulldown,
		.vco_high_band_in, .vco_low_band_in);
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// idle edge after the strobe so a following call never re-raises it in the same step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	// idle edge at the end keeps every later drive on a rising edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge sys_clk);
		sfr_rd <= 1'b0;
		#1 d = sfr_rdata;
		@(posedge sys_clk);
	endtask
	task automatic t_regs();
		logic [7:0] v;
		chk("pulldowns", 16'h0003, {14'h0, vco_high_pulldown, vco_low_pulldown});
		rd(MODE_ADDR, v);
		chk("mode reset", 16'h0000, {8'h00, v});
		wr(DATA_HI_ADDR, 8'h5a);
		rd(DATA_HI_ADDR, v);
		chk("data high", 16'h005a, {8'h00, v});
		wr(DATA_LO_ADDR, 8'ha5);
		rd(DATA_LO_ADDR, v);
		chk("data low", 16'h00a5, {8'h00, v});
		rd(8'hf4, v);
		chk("unmapped", 16'h0000, {8'h00, v});
		wr(MODE_ADDR, 8'h7f);
		rd(MODE_ADDR, v);
		chk("flag bits", 16'h0073, {8'h00, v});
		for (int p = 0; p < 4; p++) begin
			wr(MODE_ADDR, {6'h00, 2'(p)});
			@(negedge sys_clk);
			chk("pulldown pair", {14'h0, p != 1, p < 2},
				{14'h0, vco_high_pulldown, vco_low_pulldown});
			@(posedge sys_clk);
		end
	endtask
	// fast reference so every division end clears a pending down request
	task automatic t_period(input logic [7:0] mode, input logic [15:0] data,
		input logic [15:0] per, input int n);
		int t0;
		int falls;
		int bad;
		logic prev;
		t0 = -1;
		falls = 0;
		bad = 0;
		prev = 1'b0;
		vco_per <= per;
		wr(DATA_HI_ADDR, data[15:8]);
		wr(DATA_LO_ADDR, data[7:0]);
		wr(MODE_ADDR, mode);
		repeat (3000) @(posedge sys_clk);
		// every division end must fall exactly n vco periods after the last
		for (int i = 0; i < 3000; i++) begin
			@(negedge sys_clk);
			bad += (lower_request === 1'b1) &&
				(phase_error_oe_n !== 1'b0 || phase_error_out !== 1'b0);
			if (prev === 1'b1 && lower_request === 1'b0) begin
				if (t0 >= 0) begin
					chk("divide period", 16'(n * per), 16'(i - t0));
				end
				t0 = i;
				falls++;
			end
			prev = lower_request;
		end
		chk("period seen", 16'h0001, 16'(falls > 1));
		chk("pin driven low", 16'h0000, 16'(bad));
		@(posedge sys_clk);
	endtask
	task automatic t_up();
		int dn;
		int up;
		int bad;
		logic [7:0] v;
		dn = 0;
		up = 0;
		bad = 0;
		wr(MODE_ADDR, 8'h13);
		repeat (2000) @(posedge sys_clk);
		repeat (16000) begin
			@(negedge sys_clk);
			dn += (lower_request !== 1'b0);
			up += (upper_request_n === 1'b0);
			bad += (phase_error_oe_n !== upper_request_n) ||
				(upper_request_n === 1'b0 && phase_error_out !== 1'b1);
		end
		chk("down cycles", 16'h0000, 16'(dn));
		chk("up seen", 16'h0001, 16'(up > 0));
		chk("pin driven high", 16'h0000, 16'(bad));
		@(posedge sys_clk);
		rd(MODE_ADDR, v);
		chk("flags set", 16'h001f, {8'h00, v});
		rd(MODE_ADDR, v);
		chk("flags clear", 16'h0013, {8'h00, v});
		// polling slower than one reference period sees the flags set again
		repeat (7300) @(posedge sys_clk);
		rd(MODE_ADDR, v);
		chk("flags again", 16'h001f, {8'h00, v});
	endtask
	task automatic conclude();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		t_regs();
		t_period(8'hd1, 16'h0102, 16'h0002, 258);
		t_period(8'hd2, 16'h0101, 16'h0003, 257);
		t_period(8'hd3, 16'h010f, 16'h000c, 16);
		t_up();
		conclude();
	end
	// watchdog well beyond the roughly 43400 cycles of the tests
	initial begin
		#600000;
		error_cnt++;
		conclude();
	end
endmodule
